//--- tsd_addr_gen.sv
// shared constants and the mask memory address generator
`timescale 1ns/1ns
package tsd_pkg;
  localparam int DW       = 16;
  localparam int BSW_W    = 6;
  localparam int ACC_W    = 12;
  localparam int IDX_W    = 11;
  localparam int CTRL_W   = 8;
  localparam int FLAG_W   = 4;
  localparam logic [5:0]  BSW_RST = 6'h00;
  localparam logic [11:0] ACC_RST = 12'h000;
  localparam logic [15:0] LUT_RST = 16'h0000;
  localparam logic [7:0]  STEP_RST = 8'h11;
  localparam int BSW_SWAP = 0;
  localparam int ACC_RND  = 0;
  localparam int ACC_SUB  = 1;
  localparam int ACC_ACCU = 2;
  localparam int ACC_TWOS = 3;
  localparam int ACC_XCH  = 4;
  localparam int ACC_HIEN = 6;
  localparam int ACC_LOEN = 7;
  localparam int LUT_SQRT = 15;
  localparam logic [7:0]  X_CONST_HI = 8'h00;
  localparam logic [7:0]  X_CONST_LO = 8'h01;
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;
  localparam logic [15:0] RCP_SAT    = 16'hffff;
  localparam logic [16:0] RCP_ONE    = 17'h10000;
  typedef enum logic [3:0] {
    SRC_NONE, SRC_RCP_COEF, SRC_SQR_COEF, SRC_LUT, SRC_BSW, SRC_ACC,
    SRC_ZERO_HI, SRC_ZERO_LO, SRC_ZERO_ALL, SRC_MASK
  } tsd_src_e;
  typedef enum logic [2:0] {
    DST_NONE, DST_BSW, DST_ACC, DST_LUT, DST_MASK_X, DST_MASK_Y,
    DST_MASK_STEP, DST_MASK_DATA
  } tsd_dst_e;
  typedef enum logic [1:0] {XC_REF, XC_CUR, XC_CONST, XC_BUS} tsd_xch_e;
  typedef enum logic [1:0] {XL_BMA, XL_BMB, XL_CONST, XL_BUS} tsd_xlo_e;
endpackage

module tsd_addr_gen
  import tsd_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_data,
  input  wire logic       i_ld_x,
  input  wire logic       i_ld_y,
  input  wire logic       i_ld_step,
  input  wire logic       i_adv,
  output logic      [7:0] o_x,
  output logic      [7:0] o_y
);
  typedef struct packed {
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] step;
  } tsd_ag_s;

  tsd_ag_s ag_ff;
  tsd_ag_s nxt_ag;
  logic [8:0] x_sum;

  // step low nibble moves x, high nibble moves y on each x wrap
  always_comb begin
    nxt_ag = ag_ff;
    x_sum  = {1'b0, ag_ff.x} + {5'h00, ag_ff.step[3:0]};
    if (i_adv) begin
      nxt_ag.x = x_sum[7:0];
      if (x_sum[8]) begin
        nxt_ag.y = ag_ff.y + {4'h0, ag_ff.step[7:4]};
      end
    end
    if (i_ld_x) begin
      nxt_ag.x = i_data;
    end
    if (i_ld_y) begin
      nxt_ag.y = i_data;
    end
    if (i_ld_step) begin
      nxt_ag.step = i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ag_ff <= '{x: 8'h00, y: 8'h00, step: STEP_RST};
    end else begin
      ag_ff <= nxt_ag;
    end
  end

  assign o_x = ag_ff.x;
  assign o_y = ag_ff.y;
endmodule // tsd_addr_gen

//--- tsd_top.sv
// track support datapath: tables, bank swap, accumulator control, mask, zero buffer
`timescale 1ns/1ns

// Overview of operation
// - 2Kx16 reciprocal coefficients, indexed, either bus
// - square-root coefficient table addressed by index
// - 64K table addressed by bus-loaded register
// - straight region: operand is address, result out
// - straight reciprocal times operand gives 10000h
// - six-bit swap register, one live bit
// - memory controls and flags routed by swap
// - twelve-bit accumulator control register, readable
// - low four bits drive accumulator terms
// - next four bits select accumulator input
// - decoder makes four byte enables, three selects
// - input selector: memory A, B, 0001, bus
// - mask memory 256x256 bits, same addressing
// - mask written packed, read bit by bit
// - zero buffer drives zeros on either half
module tsd_top
  import tsd_pkg::*;
(
  input  wire logic              I_REF_CLK,
  input  wire logic              I_RST_N,
  input  wire logic [DW-1:0]     I_MDB_DATA,
  input  wire logic [3:0]        I_MDB_SRC,
  input  wire logic [2:0]        I_MDB_DST,
  input  wire logic              I_SDB_RCP,
  input  wire logic [IDX_W-1:0]  I_INDEX,
  input  wire logic              I_MASK_ADV,
  input  wire logic [CTRL_W-1:0] I_REF_CTRL,
  input  wire logic [CTRL_W-1:0] I_CUR_CTRL,
  input  wire logic [FLAG_W-1:0] I_BMA_FLAG,
  input  wire logic [FLAG_W-1:0] I_BMB_FLAG,
  input  wire logic [7:0]        I_BMA_DATA,
  input  wire logic [7:0]        I_BMB_DATA,
  output logic      [DW-1:0]     O_MDB_DATA,
  output logic      [1:0]        O_MDB_OE,
  output logic      [DW-1:0]     O_SDB_DATA,
  output logic                   O_SDB_OE,
  output logic      [CTRL_W-1:0] O_BMA_CTRL,
  output logic      [CTRL_W-1:0] O_BMB_CTRL,
  output logic      [FLAG_W-1:0] O_REF_FLAG,
  output logic      [FLAG_W-1:0] O_CUR_FLAG,
  output logic                   O_ACC_ROUND,
  output logic                   O_ACC_SUB,
  output logic                   O_ACC_ACCUM,
  output logic                   O_ACC_TWOS,
  output logic      [3:0]        O_BYTE_EN,
  output logic      [2:0]        O_XSEL,
  output logic      [DW-1:0]     O_X_DATA
);
  typedef struct packed {
    logic [BSW_W-1:0]  bsw;
    logic [ACC_W-1:0]  acc;
    logic [DW-1:0]     lut_addr;
    logic [DW-1:0]     mdb;
    logic [1:0]        mdb_oe;
    logic [DW-1:0]     sdb;
    logic              sdb_oe;
    logic [CTRL_W-1:0] bma_ctrl;
    logic [CTRL_W-1:0] bmb_ctrl;
    logic [FLAG_W-1:0] ref_flag;
    logic [FLAG_W-1:0] cur_flag;
    logic [3:0]        terms;
    logic [3:0]        ben;
    logic [2:0]        xsel;
    logic [DW-1:0]     xdata;
  } tsd_top_s;

  tsd_top_s st_ff;
  tsd_top_s nxt_st;

  // byte-packed mask store: 256 rows of 32 bytes
  logic [7:0] mask_mem [8192];
  logic [7:0] mask_x;
  logic [7:0] mask_y;
  logic [7:0] mask_byte;
  logic       swap;
  logic [6:0] map;
  tsd_src_e   src;
  tsd_dst_e   dst;

  assign src  = tsd_src_e'(I_MDB_SRC);
  assign dst  = tsd_dst_e'(I_MDB_DST);
  assign swap = st_ff.bsw[BSW_SWAP];

  function automatic logic [15:0] isqrt(input logic [31:0] v);
    logic [31:0] r;
    r = 32'h0;
    for (int b = 15; b >= 0; b--) begin
      if ((r | (32'h1 << b)) * (r | (32'h1 << b)) <= v) begin
        r = r | (32'h1 << b);
      end
    end
    return r[15:0];
  endfunction

  // segment = idx[10:2], coefficient number = idx[1:0]; fourth slot reads zero
  function automatic logic [15:0] rcp_coef(input logic [IDX_W-1:0] idx);
    longint x0;
    longint c;
    x0 = 64'd512 + longint'(idx[10:2]);
    unique case (idx[1:0])
      2'd0:    c = 64'h1000000 / x0;
      2'd1:    c = 64'h200000000 / (x0 * x0);
      2'd2:    c = 64'h40000000000 / (x0 * x0 * x0);
      default: c = 64'h0;
    endcase
    return c[15:0];
  endfunction

  function automatic logic [15:0] sqr_coef(input logic [IDX_W-1:0] idx);
    longint x0;
    longint r0;
    longint c;
    x0 = 64'd512 + longint'(idx[10:2]);
    r0 = longint'(isqrt(32'(x0 << 21)));
    unique case (idx[1:0])
      2'd0:    c = r0;
      2'd1:    c = 64'h40000000 / r0;
      2'd2:    c = 64'h8000000000 / (x0 * r0);
      default: c = 64'h0;
    endcase
    return c[15:0];
  endfunction

  // bit 15 clear: straight reciprocal, set: straight square root of a.15
  function automatic logic [15:0] lut_word(input logic [15:0] a);
    logic [16:0] q;
    q = 17'h0;
    if (a[LUT_SQRT]) begin
      return isqrt({1'b0, a[14:0], 16'h0000});
    end
    if (a < 16'h0002) begin
      return RCP_SAT;
    end
    q = RCP_ONE / {1'b0, a};
    return q[15:0];
  endfunction

  // out: {A hi, A lo, B hi, B lo, upper-bus select, low select[1:0]}
  function automatic logic [6:0] xmap(input logic [3:0] sel, input logic sw);
    logic phys_b;
    logic hi;
    logic lo;
    logic [1:0] xl;
    phys_b = 1'b0;
    hi     = sel[ACC_HIEN-ACC_XCH];
    lo     = sel[ACC_LOEN-ACC_XCH];
    xl     = XL_CONST;
    unique case (tsd_xch_e'(sel[1:0]))
      XC_REF: begin
        phys_b = sw;
        xl     = sw ? XL_BMB : XL_BMA;
      end
      XC_CUR: begin
        phys_b = !sw;
        xl     = sw ? XL_BMA : XL_BMB;
      end
      XC_CONST: xl = XL_CONST;
      XC_BUS:   xl = XL_BUS;
    endcase
    if (sel[1]) begin
      hi = 1'b0;
      lo = 1'b0;
    end
    return {hi && !phys_b, lo && !phys_b, hi && phys_b, lo && phys_b,
            xl == XL_BUS, xl};
  endfunction

  tsd_addr_gen u_mask_ag (
    .i_clk     (I_REF_CLK),
    .i_rst_n   (I_RST_N),
    .i_data    (I_MDB_DATA[7:0]),
    .i_ld_x    (dst == DST_MASK_X),
    .i_ld_y    (dst == DST_MASK_Y),
    .i_ld_step (dst == DST_MASK_STEP),
    .i_adv     (I_MASK_ADV),
    .o_x       (mask_x),
    .o_y       (mask_y)
  );

  // low three x bits bypass the array and pick the bit
  always_ff @(posedge I_REF_CLK) begin
    if (dst == DST_MASK_DATA) begin
      mask_mem[{mask_y, mask_x[7:3]}] <= I_MDB_DATA[7:0];
    end
  end
  assign mask_byte = mask_mem[{mask_y, mask_x[7:3]}];

  assign map = xmap(st_ff.acc[ACC_XCH +: 4], swap);

  always_comb begin
    nxt_st = st_ff;
    unique case (dst)
      DST_BSW: nxt_st.bsw      = I_MDB_DATA[BSW_W-1:0];
      DST_ACC: nxt_st.acc      = I_MDB_DATA[ACC_W-1:0];
      DST_LUT: nxt_st.lut_addr = I_MDB_DATA;
      default: ;
    endcase
    // accumulator terms follow the value being written in the same edge; byte enables and selects follow one cycle later
    nxt_st.terms = nxt_st.acc[ACC_TWOS:ACC_RND];
    nxt_st.ben   = map[6:3];
    nxt_st.xsel  = map[2:0];
    // only the swap bit has effect; the other five bits are storage
    nxt_st.bma_ctrl = swap ? I_CUR_CTRL : I_REF_CTRL;
    nxt_st.bmb_ctrl = swap ? I_REF_CTRL : I_CUR_CTRL;
    nxt_st.ref_flag = swap ? I_BMB_FLAG : I_BMA_FLAG;
    nxt_st.cur_flag = swap ? I_BMA_FLAG : I_BMB_FLAG;
    unique case (tsd_xlo_e'(map[1:0]))
      XL_BMA:   nxt_st.xdata[7:0] = I_BMA_DATA;
      XL_BMB:   nxt_st.xdata[7:0] = I_BMB_DATA;
      XL_CONST: nxt_st.xdata[7:0] = X_CONST_LO;
      XL_BUS:   nxt_st.xdata[7:0] = I_MDB_DATA[7:0];
    endcase
    nxt_st.xdata[15:8] = map[2] ? I_MDB_DATA[15:8] : X_CONST_HI;
    nxt_st.mdb_oe = 2'b11;
    nxt_st.mdb    = '0;
    unique case (src)
      SRC_RCP_COEF: nxt_st.mdb = rcp_coef(I_INDEX);
      SRC_SQR_COEF: nxt_st.mdb = sqr_coef(I_INDEX);
      SRC_LUT:      nxt_st.mdb = lut_word(st_ff.lut_addr);
      SRC_BSW:      nxt_st.mdb = {{(DW-BSW_W){1'b0}}, st_ff.bsw};
      SRC_ACC:      nxt_st.mdb = {{(DW-ACC_W){1'b0}}, st_ff.acc};
      SRC_ZERO_HI:  nxt_st.mdb_oe = 2'b10;
      SRC_ZERO_LO:  nxt_st.mdb_oe = 2'b01;
      SRC_ZERO_ALL: nxt_st.mdb    = {ZERO_BYTE, ZERO_BYTE};
      SRC_MASK:     nxt_st.mdb    = {15'h0000, mask_byte[mask_x[2:0]]};
      default:      nxt_st.mdb_oe = 2'b00;
    endcase
    nxt_st.sdb_oe = I_SDB_RCP;
    nxt_st.sdb    = I_SDB_RCP ? rcp_coef(I_INDEX) : '0;
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_ff          <= '0;
      st_ff.bsw      <= BSW_RST;
      st_ff.acc      <= ACC_RST;
      st_ff.lut_addr <= LUT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign O_MDB_DATA  = st_ff.mdb;
  assign O_MDB_OE    = st_ff.mdb_oe;
  assign O_SDB_DATA  = st_ff.sdb;
  assign O_SDB_OE    = st_ff.sdb_oe;
  assign O_BMA_CTRL  = st_ff.bma_ctrl;
  assign O_BMB_CTRL  = st_ff.bmb_ctrl;
  assign O_REF_FLAG  = st_ff.ref_flag;
  assign O_CUR_FLAG  = st_ff.cur_flag;
  assign O_ACC_ROUND = st_ff.terms[ACC_RND];
  assign O_ACC_SUB   = st_ff.terms[ACC_SUB];
  assign O_ACC_ACCUM = st_ff.terms[ACC_ACCU];
  assign O_ACC_TWOS  = st_ff.terms[ACC_TWOS];
  assign O_BYTE_EN   = st_ff.ben;
  assign O_XSEL      = st_ff.xsel;
  assign O_X_DATA    = st_ff.xdata;

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_N);

  chk_swap_write: assert property (
    dst == DST_BSW ##1 src == SRC_BSW
    |=> O_MDB_DATA == {10'h000, $past(I_MDB_DATA[5:0], 2)})
    else $error("swap register readback wrong");

  chk_acc_readback: assert property (
    dst == DST_ACC ##1 (src == SRC_ACC && dst != DST_ACC)
    |=> O_MDB_DATA == {4'h0, $past(I_MDB_DATA[11:0], 2)} && O_MDB_OE == 2'b11)
    else $error("accumulator control readback wrong");

  chk_acc_terms: assert property (
    dst == DST_ACC |=> {O_ACC_TWOS, O_ACC_ACCUM, O_ACC_SUB, O_ACC_ROUND}
    == $past(I_MDB_DATA[3:0]))
    else $error("accumulator terms do not follow write");

  chk_ctrl_route: assert property (
    $past(I_RST_N) |-> O_BMA_CTRL == ($past(swap) ? $past(I_CUR_CTRL) : $past(I_REF_CTRL))
    && O_REF_FLAG == ($past(swap) ? $past(I_BMB_FLAG) : $past(I_BMA_FLAG)))
    else $error("block memory routing ignores swap bit");

  chk_byte_enables: assert property (
    dst == DST_ACC && I_MDB_DATA[7:4] == 4'h4 && !swap && dst != DST_BSW
    |-> ##2 O_BYTE_EN == 4'b1000 && O_XSEL == 3'b000)
    else $error("reference upper enable not on memory A");

  chk_xsel_const: assert property (
    O_XSEL[1:0] == 2'b10 |=> O_X_DATA == {X_CONST_HI, X_CONST_LO} || $past(dst) == DST_ACC)
    else $error("constant input not 0001");

  chk_recip_value: assert property (
    src == SRC_LUT && !st_ff.lut_addr[15] && st_ff.lut_addr > 16'h0001
    |=> (32'(O_MDB_DATA) * 32'($past(st_ff.lut_addr)) <= 32'h10000)
    && (32'(O_MDB_DATA + 16'h1) * 32'($past(st_ff.lut_addr)) > 32'h10000))
    else $error("straight reciprocal wrong");

  chk_zero_upper: assert property (
    src == SRC_ZERO_HI |=> O_MDB_OE == 2'b10 && O_MDB_DATA[15:8] == ZERO_BYTE)
    else $error("zero buffer upper half wrong");

  chk_table_latency: assert property (
    src == SRC_RCP_COEF ##1 src == SRC_NONE |-> O_MDB_OE == 2'b11 ##1 O_MDB_OE == 2'b00)
    else $error("table word not one cycle");

  chk_zero_lower: assert property (
    src == SRC_ZERO_LO |=> O_MDB_OE == 2'b01 && O_MDB_DATA[7:0] == ZERO_BYTE)
    else $error("zero buffer lower half wrong");

  chk_zero_both: assert property (
    src == SRC_ZERO_ALL |=> O_MDB_OE == 2'b11 && O_MDB_DATA == {ZERO_BYTE, ZERO_BYTE})
    else $error("zero buffer full word wrong");

  chk_second_bus: assert property (
    I_SDB_RCP && src == SRC_RCP_COEF |=> O_SDB_OE && O_SDB_DATA == O_MDB_DATA)
    else $error("coefficient word differs between buses");

  chk_sqrt_straight: assert property (
    src == SRC_LUT && st_ff.lut_addr[LUT_SQRT]
    |=> 32'(O_MDB_DATA) * 32'(O_MDB_DATA)
        <= {1'b0, $past(st_ff.lut_addr[14:0]), 16'h0000}
    && 32'(O_MDB_DATA + 16'h1) * 32'(O_MDB_DATA + 16'h1)
       > {1'b0, $past(st_ff.lut_addr[14:0]), 16'h0000})
    else $error("straight square root wrong");

  chk_mask_bit: assert property (
    src == SRC_MASK |=> O_MDB_OE == 2'b11 && O_MDB_DATA[15:1] == 15'h0000)
    else $error("mask read not a single bit");

  chk_bus_release: assert property (
    src == SRC_NONE |=> O_MDB_OE == 2'b00 && O_MDB_DATA == 16'h0000)
    else $error("main bus still driven without a source");

  chk_ctrl_current: assert property (
    $past(I_RST_N) |-> O_BMB_CTRL == ($past(swap) ? $past(I_REF_CTRL) : $past(I_CUR_CTRL))
    && O_CUR_FLAG == ($past(swap) ? $past(I_BMA_FLAG) : $past(I_BMB_FLAG)))
    else $error("current memory routing ignores swap bit");

  cov_swap_toggle: cover property (dst == DST_BSW ##1 dst == DST_BSW);
  cov_lut_sqrt:    cover property (src == SRC_LUT && st_ff.lut_addr[15]);
  cov_mask_read:   cover property (dst == DST_MASK_DATA ##1 src == SRC_MASK);
  cov_bus_input:   cover property (O_XSEL == 3'b111);
  cov_both_buses:  cover property (I_SDB_RCP && src == SRC_RCP_COEF);
endmodule // tsd_top

//--- tsd_seq_model.sv
// microcode sequencer model driving the main bus source and destination fields
`timescale 1ns/1ns
module tsd_seq_model
  import tsd_pkg::*;
(
  input  wire logic          i_clk,
  output logic      [3:0]    o_src,
  output logic      [2:0]    o_dst,
  output logic      [DW-1:0] o_data
);
  initial begin
    o_src  = 4'h0;
    o_dst  = 3'h0;
    o_data = 16'h0000;
  end

  // destination acts as a one-cycle strobe; data is held up to the taking edge
  task automatic wr(input logic [2:0] d, input logic [DW-1:0] v);
    @(posedge i_clk);
    o_dst  <= d;
    o_data <= v;
    @(posedge i_clk);
    o_dst  <= 3'h0;
    o_data <= ~v; // released bus must not keep showing the old word
  endtask

  // source code stands one cycle; the answer is settled just after the taking edge
  task automatic rd(input logic [3:0] s);
    @(posedge i_clk);
    o_src <= s;
    @(posedge i_clk);
    o_src <= 4'h0;
    #1;
  endtask

  // write then read in the very next cycle, the tightest order the bus allows
  task automatic wr_rd(input logic [2:0] d, input logic [DW-1:0] v, input logic [3:0] s);
    @(posedge i_clk);
    o_dst  <= d;
    o_data <= v;
    @(posedge i_clk);
    o_dst  <= 3'h0;
    o_data <= ~v;
    o_src  <= s;
    @(posedge i_clk);
    o_src  <= 4'h0;
    #1;
  endtask

  // reference image obsolete: flip only the live swap bit and carry on tracking
  task automatic swap(input logic [DW-1:0] cur);
    wr(DST_BSW, cur ^ 16'h0001);
  endtask
endmodule // tsd_seq_model

//--- tsd_top_tb.sv
// self-checking bench for the track support datapath
`timescale 1ns/1ns
module tsd_top_tb;
  import tsd_pkg::*;
  logic             clk      = 1'b0;
  logic             rst_n    = 1'b0;
  logic             sdb_rcp  = 1'b0;
  logic [IDX_W-1:0] index    = '0;
  logic             adv      = 1'b0;
  logic [7:0]       ref_ctrl = 8'ha5;
  logic [7:0]       cur_ctrl = 8'h3c;
  logic [3:0]       fa       = 4'h1;
  logic [3:0]       fb       = 4'h2;
  logic [3:0]       src;
  logic [2:0]       dst;
  logic [DW-1:0]    bus_in, mdb, sdb, x_data;
  logic [1:0]       oe;
  logic             sdb_oe, rnd, sub, accu, twos;
  logic [7:0]       bma, bmb;
  logic [3:0]       ref_f, cur_f, be;
  logic [2:0]       xsel;
  int               n_errors = 0;
  int               cmp_count = 0;
  logic [3:0]       zc[4] = '{4'h6, 4'h7, 4'h8, 4'ha};
  logic [1:0]       zo[4] = '{2'h2, 2'h1, 2'h3, 2'h0};
  logic [15:0]      la[7] = '{16'h0001, 16'h0003, 16'h0004, 16'h7fff, 16'h8000, 16'h8001, 16'h8004};
  logic [15:0]      le[7] = '{16'hffff, 16'h5555, 16'h4000, 16'h0002, 16'h0000, 16'h0100, 16'h0200};
  logic [15:0]      ce[5] = '{16'h8000, 16'h8000, 16'h8000, 16'h0000, 16'h7fc0};
  logic [15:0]      av[3] = '{16'h00c0, 16'h0090, 16'h0020};
  logic [15:0]      ae[3] = '{16'h0019, 16'h0020, 16'h0002};
  logic [15:0]      ax[3] = '{16'h00c3, 16'h005a, 16'h0001};

  always #20 clk = ~clk;

  tsd_seq_model seq (.i_clk(clk), .o_src(src), .o_dst(dst), .o_data(bus_in));

  tsd_top dut (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_MDB_DATA(bus_in), .I_MDB_SRC(src), .I_MDB_DST(dst),
    .I_SDB_RCP(sdb_rcp), .I_INDEX(index), .I_MASK_ADV(adv), .I_REF_CTRL(ref_ctrl),
    .I_CUR_CTRL(cur_ctrl), .I_BMA_FLAG(fa), .I_BMB_FLAG(fb), .I_BMA_DATA(8'h5a),
    .I_BMB_DATA(8'hc3), .O_MDB_DATA(mdb), .O_MDB_OE(oe), .O_SDB_DATA(sdb), .O_SDB_OE(sdb_oe),
    .O_BMA_CTRL(bma), .O_BMB_CTRL(bmb), .O_REF_FLAG(ref_f), .O_CUR_FLAG(cur_f),
    .O_ACC_ROUND(rnd), .O_ACC_SUB(sub), .O_ACC_ACCUM(accu), .O_ACC_TWOS(twos),
    .O_BYTE_EN(be), .O_XSEL(xsel), .O_X_DATA(x_data)
  );

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    seq.rd(SRC_BSW);
    chk(mdb, 16'h0000);
    chk({14'h0, oe}, 16'h0003);
    seq.rd(SRC_ACC);
    chk(mdb, 16'h0000);
    seq.wr_rd(DST_BSW, 16'hfffe, SRC_BSW);
    chk(mdb, 16'h003e);
    chk({bma, bmb}, 16'ha53c);
    chk({8'h0, ref_f, cur_f}, 16'h0012);
    seq.wr_rd(DST_ACC, 16'hfff5, SRC_ACC);
    chk(mdb, 16'h0ff5);
    chk({12'h0, twos, accu, sub, rnd}, 16'h0005);
    chk({9'h0, be, xsel}, 16'h0007);
    chk(x_data, 16'h000a);
    for (int i = 0; i < 4; i++) begin
      seq.rd(zc[i]);
      chk(mdb, 16'h0000);
      chk({14'h0, oe}, {14'h0, zo[i]});
    end
    for (int i = 0; i < 7; i++) begin
      seq.wr(DST_LUT, la[i]);
      seq.rd(SRC_LUT);
      chk(mdb, le[i]);
    end
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) index <= IDX_W'(i);
      seq.rd(SRC_RCP_COEF);
      chk(mdb, ce[i]);
      seq.rd(SRC_SQR_COEF);
      if (i < 4) chk(mdb, ce[i]);
    end
    // second bus word stands right after the edge that samples the select
    @(posedge clk) sdb_rcp <= 1'b1;
    @(posedge clk);
    #1;
    chk({sdb_oe, sdb[14:0]}, 16'hffc0);
    seq.rd(SRC_RCP_COEF);
    chk(mdb, ce[4]);
    chk(sdb, ce[4]);
    @(posedge clk) sdb_rcp <= 1'b0;
    seq.wr(DST_ACC, 16'h0040);
    seq.rd(SRC_NONE);
    chk({9'h0, be, xsel}, 16'h0040);
    chk(x_data, 16'h005a);
    seq.wr(DST_ACC, 16'h00c0);
    seq.rd(SRC_NONE);
    chk({9'h0, be, xsel}, 16'h0060);
    chk(x_data, 16'h005a);
    seq.swap(16'h003e);
    seq.rd(SRC_BSW);
    chk(mdb, 16'h003f);
    chk({bma, bmb}, 16'h3ca5);
    chk({8'h0, ref_f, cur_f}, 16'h0021);
    for (int i = 0; i < 3; i++) begin
      seq.wr(DST_ACC, av[i]);
      seq.rd(SRC_NONE);
      chk({9'h0, be, xsel}, ae[i]);
      chk(x_data, ax[i]);
    end
    seq.wr(DST_MASK_Y, 16'h0002);
    seq.wr(DST_MASK_X, 16'h0010);
    seq.wr_rd(DST_MASK_DATA, 16'h00a5, SRC_MASK);
    chk(mdb, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      seq.wr(DST_MASK_X, 16'h0010 + 16'(i));
      seq.rd(SRC_MASK);
      chk(mdb, 16'((8'ha5 >> i) & 8'h01));
    end
    // advance by the reset step of one moves to the next bit of the same byte
    seq.wr(DST_MASK_X, 16'h0010);
    @(posedge clk) adv <= 1'b1;
    @(posedge clk) adv <= 1'b0;
    seq.rd(SRC_MASK);
    chk(mdb, 16'h0000);
    complete_run();
  end

  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
endmodule // tsd_top_tb
